// ### hdl/hpcm_pkg.sv
package hpcm_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_ID1 = 6'h00;
  localparam logic [5:0] IDX_ID2 = 6'h01;
  localparam logic [5:0] IDX_REV = 6'h02;
  localparam logic [5:0] IDX_CFG = 6'h20;
  localparam logic [5:0] IDX_MUTE = 6'h21;
  localparam logic [5:0] IDX_STAT = 6'h22;
  // Configuration register fields
  localparam int CFG_CONV_SRC = 0;
  localparam int CFG_PTX_SRC = 1;
  localparam int CFG_SPDIF_SRC = 2;
  localparam int CFG_FMT = 4;
  localparam int CFG_ROLE = 6;
  localparam int CFG_PWDN = 7;
  localparam int CFG_CONT_RD = 8;
  localparam int CFG_RATIO = 9;
  localparam int CFG_BCLK = 12;
  localparam logic [13:0] CFG_RST = 14'h0480;
  // Mute register fields
  localparam int MUT_SEL = 0;
  localparam int MUT_PDIS = 3;
  localparam logic [3:0] MUT_RST = 4'h0;
  // Synchronised pin positions
  localparam int SY_HW = 0;
  localparam int SY_R1 = 1;
  localparam int SY_R2 = 2;
  localparam int SY_R3 = 3;
  localparam int SY_R4 = 4;
  localparam int SY_CS = 5;
  localparam int SY_SCK = 6;
  localparam int SY_MUTE = 7;
  localparam int SY_SDI = 8;
  localparam int SY_PD = 9;
  localparam int SY_FLT = 10;
  localparam int SY_N = 11;
  // Encodings
  localparam logic [1:0] TXS_SPDIF = 2'h0;
  localparam logic [1:0] TXS_ADC = 2'h1;
  localparam logic [1:0] TXS_PORT = 2'h3;
  localparam logic [1:0] FMT_RJ24 = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h3;
  localparam logic [2:0] RATIO_256FS = 3'h2;
  localparam logic [1:0] BCLK_64 = 2'h0;
  localparam logic CLK_INT = 1'b0;
  localparam logic CLK_EXT = 1'b1;
endpackage

// ### hdl/hpcm_top.sv
`timescale 1ns/1ns
// Operation
// - Indices 0..2 read two ID bytes and revision, not in continuous readback
// - Mode pin low selects software control, high selects hardware control
// - Route pin one picks DAC source, route pin two primary TX source
// - Route pins four/three pick S/PDIF TX source; code 10 undefined
// - Wire-count pin outputs unlock flag in hardware mode
// - Serial out pin drives non-PCM OR channel-status bit one
// - Pin eight gives channel bit, pin nine high in sub-frame A
// - Pin ten high for all of frame 0 of each block
// - Chip-select and serial clock pins pick primary port format
// - Hardware mode: mute pin high soft-mutes all DACs
// - Software mode: mute pin mutes selected DAC unless pin disabled
// - Floating mute pin becomes output showing all-DAC zero detect
// - Serial in pin picks primary TX slave or master role
// - Hardware mode uses 256fs ratio and 64 bit clocks per frame
// - Corrupt or invalid sub-frames repeat last valid sample on the DAC path
// - S/PDIF-to-S/PDIF path substitutes only on validity errors
// - Software mode starts powered down; hardware mode follows powerdown pin
// - Master with receiver on: internal clock, port drives bit/frame clocks
// - Port with ADC and DACs with S/PDIF: split clock sources
module hpcm_top
  import hpcm_pkg::*;
#(
  parameter logic [7:0] ID1_VAL = 8'h5a, // arbitrary
  parameter logic [7:0] ID2_VAL = 8'h3c, // arbitrary
  parameter logic [7:0] REV_VAL = 8'h01  // arbitrary
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic control_method_select_pin,
  input wire logic route_pin_one,
  input wire logic route_pin_two,
  input wire logic route_pin_three,
  input wire logic route_pin_four,
  input wire logic chip_select_pin,
  input wire logic serial_clock_pin,
  input wire logic mute_pin_in,
  input wire logic mute_pin_float,
  input wire logic serial_in_pin,
  input wire logic global_powerdown_pin,
  input wire logic rx_unlock,
  input wire logic rx_pcm_n,
  input wire logic rx_audio_n,
  input wire logic rx_subframe_strobe,
  input wire logic rx_subframe_a,
  input wire logic rx_channel_bit,
  input wire logic rx_block_start,
  input wire logic [23:0] rx_sample,
  input wire logic rx_parity_err,
  input wire logic rx_biphase_err,
  input wire logic rx_validity,
  input wire logic [2:0] dac_zero,
  output logic hw_mode,
  output logic converter_source_select,
  output logic primary_tx_source_select,
  output logic [1:0] spdif_out_source_select,
  output logic [1:0] port_format,
  output logic primary_tx_role_bit,
  output logic [2:0] primary_tx_clock_ratio,
  output logic [1:0] bitclock_ratio_select,
  output logic [2:0] dac_soft_mute,
  output logic chip_powerdown,
  output logic serial_wire_count_pin_out,
  output logic serial_wire_count_pin_oe,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe,
  output logic multifunction_pin_eight,
  output logic subframe_indicator,
  output logic block_start_flag,
  output logic status_pins_oe,
  output logic mute_pin_out,
  output logic mute_pin_oe,
  output logic dac_clock_sel,
  output logic adc_clock_sel,
  output logic port_clock_sel,
  output logic port_clocks_oe,
  output logic master_clock_pin_oe,
  output logic [23:0] dac_path_sample,
  output logic [23:0] tx_path_sample,
  output logic sample_strobe
);

  logic [SY_N-1:0] sy1_reg;
  logic [SY_N-1:0] sy_reg;
  logic [13:0] cfg_reg;
  logic [3:0] mute_reg;
  logic [5:0] aidx_reg;
  logic wr_reg;
  logic rd_reg;
  logic sub8_reg;
  logic sub9_reg;
  logic blk_reg;
  logic [23:0] good_reg [2];
  logic [23:0] tgood_reg [2];
  logic rx_used;
  logic bad;
  logic ch;
  logic all_zero;
  logic [5:0] stat;

  // Straps cross from the board; no logic reads the first stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sy1_reg <= '0;
      sy_reg <= '0;
    end else begin
      sy1_reg <= {mute_pin_float, global_powerdown_pin, serial_in_pin,
                  mute_pin_in, serial_clock_pin, chip_select_pin,
                  route_pin_four, route_pin_three, route_pin_two,
                  route_pin_one, control_method_select_pin};
      sy_reg <= sy1_reg;
    end
  end

  assign hw_mode = sy_reg[SY_HW];

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aidx_reg <= '0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else if (hready) begin
      aidx_reg <= haddr[7:2];
      wr_reg <= hsel && htrans[1] && hwrite;
      rd_reg <= hsel && htrans[1] && !hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= CFG_RST;
    end else if (wr_reg && aidx_reg == IDX_CFG) begin
      cfg_reg <= hwdata[13:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mute_reg <= MUT_RST;
    end else if (wr_reg && aidx_reg == IDX_MUTE) begin
      mute_reg <= hwdata[3:0];
    end
  end

  assign all_zero = &dac_zero;
  assign stat = {sy_reg[SY_FLT], chip_powerdown, all_zero,
                 rx_pcm_n | rx_audio_n, rx_unlock, hw_mode};

  // Read mux over flops and raw status inputs; unmapped indices read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_reg) begin
      case (aidx_reg)
        IDX_ID1: hrdata[7:0] = cfg_reg[CFG_CONT_RD] ? 8'h00 : ID1_VAL;
        IDX_ID2: hrdata[7:0] = cfg_reg[CFG_CONT_RD] ? 8'h00 : ID2_VAL;
        IDX_REV: hrdata[7:0] = cfg_reg[CFG_CONT_RD] ? 8'h00 : REV_VAL;
        IDX_CFG: hrdata[13:0] = cfg_reg;
        IDX_MUTE: hrdata[3:0] = mute_reg;
        IDX_STAT: hrdata[5:0] = stat;
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Routing, format and role: straps in hardware mode, registers otherwise
  always_comb begin
    if (hw_mode) begin
      converter_source_select = sy_reg[SY_R1];
      primary_tx_source_select = sy_reg[SY_R2];
      spdif_out_source_select = {sy_reg[SY_R4], sy_reg[SY_R3]};
      port_format = {sy_reg[SY_CS], sy_reg[SY_SCK]};
      primary_tx_role_bit = sy_reg[SY_SDI];
      primary_tx_clock_ratio = RATIO_256FS;
      bitclock_ratio_select = BCLK_64;
      chip_powerdown = sy_reg[SY_PD];
    end else begin
      converter_source_select = cfg_reg[CFG_CONV_SRC];
      primary_tx_source_select = cfg_reg[CFG_PTX_SRC];
      spdif_out_source_select = cfg_reg[CFG_SPDIF_SRC +: 2];
      port_format = cfg_reg[CFG_FMT +: 2];
      primary_tx_role_bit = cfg_reg[CFG_ROLE];
      primary_tx_clock_ratio = cfg_reg[CFG_RATIO +: 3];
      bitclock_ratio_select = cfg_reg[CFG_BCLK +: 2];
      chip_powerdown = cfg_reg[CFG_PWDN];
    end
  end

  // A floating mute pin is an output, so it never mutes anything
  always_comb begin
    dac_soft_mute = 3'h0;
    if (!sy_reg[SY_FLT] && sy_reg[SY_MUTE]) begin
      if (hw_mode) begin
        dac_soft_mute = 3'h7;
      end else if (!mute_reg[MUT_PDIS]) begin
        dac_soft_mute = mute_reg[MUT_SEL +: 3];
      end
    end
  end

  assign mute_pin_oe = sy_reg[SY_FLT];
  assign mute_pin_out = sy_reg[SY_FLT] & all_zero;

  // Status pins are outputs only under hardware control
  assign serial_wire_count_pin_oe = hw_mode;
  assign serial_wire_count_pin_out = hw_mode & rx_unlock;
  assign serial_out_pin_oe = hw_mode;
  assign serial_out_pin_out = hw_mode & (rx_pcm_n | rx_audio_n);
  assign status_pins_oe = hw_mode;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub8_reg <= 1'b0;
      sub9_reg <= 1'b0;
    end else if (rx_subframe_strobe) begin
      sub8_reg <= rx_channel_bit;
      sub9_reg <= rx_subframe_a;
    end
  end

  // Block flag spans both sub-frames of frame 0 only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blk_reg <= 1'b0;
    end else if (rx_subframe_strobe && rx_subframe_a) begin
      blk_reg <= rx_block_start;
    end
  end

  assign multifunction_pin_eight = hw_mode & sub8_reg;
  assign subframe_indicator = hw_mode & sub9_reg;
  assign block_start_flag = hw_mode & blk_reg;

  // Clock routing; receiver counts as on when any path takes it
  assign rx_used = !converter_source_select || !primary_tx_source_select ||
                   spdif_out_source_select == TXS_SPDIF;

  always_comb begin
    if (rx_used) begin
      adc_clock_sel = CLK_INT;
      dac_clock_sel = CLK_INT;
      port_clock_sel = CLK_INT;
      if (primary_tx_source_select && !converter_source_select) begin
        port_clock_sel = CLK_EXT;
      end
    end else begin
      adc_clock_sel = CLK_EXT;
      dac_clock_sel = CLK_EXT;
      port_clock_sel = CLK_EXT;
    end
  end

  // Slave relies on supplied clocks being synchronous to S/PDIF
  assign port_clocks_oe = primary_tx_role_bit;
  assign master_clock_pin_oe = 1'b0;

  // Concealment keeps the last good sample per sub-frame channel
  assign ch = rx_subframe_a;
  assign bad = rx_parity_err | rx_biphase_err | rx_validity;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      good_reg[0] <= '0;
      good_reg[1] <= '0;
      dac_path_sample <= '0;
    end else if (rx_subframe_strobe) begin
      if (bad) begin
        dac_path_sample <= good_reg[ch];
      end else begin
        dac_path_sample <= rx_sample;
        good_reg[ch] <= rx_sample;
      end
    end
  end

  // Parity and biphase errors pass through to the transmitter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgood_reg[0] <= '0;
      tgood_reg[1] <= '0;
      tx_path_sample <= '0;
    end else if (rx_subframe_strobe) begin
      if (rx_validity) begin
        tx_path_sample <= tgood_reg[ch];
      end else begin
        tx_path_sample <= rx_sample;
        tgood_reg[ch] <= rx_sample;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= rx_subframe_strobe;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [1:0] rst_age;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_age <= 2'h0;
    end else if (rst_age != 2'h3) begin
      rst_age <= rst_age + 2'h1;
    end
  end

  AST_ID_READ: assert property (
    hsel && htrans[1] && !hwrite && hready && haddr[7:2] == IDX_ID1
    && !cfg_reg[CFG_CONT_RD] |=> hrdata[7:0] == ID1_VAL)
    else $error("ID byte wrong");
  AST_ID_BLOCK: assert property (
    rd_reg && aidx_reg <= IDX_REV && cfg_reg[CFG_CONT_RD]
    |-> hrdata == 32'h0000_0000)
    else $error("ID visible in continuous readback");
  AST_MODE: assert property (
    rst_age == 2'h3 |-> hw_mode == $past(control_method_select_pin, 2))
    else $error("Mode not following strap");
  AST_DAC_ROUTE: assert property (
    rst_age == 2'h3 && hw_mode
    |-> converter_source_select == $past(route_pin_one, 2))
    else $error("DAC source not from route pin");
  AST_TX_ROUTE: assert property (
    rst_age == 2'h3 && hw_mode |-> spdif_out_source_select
    == {$past(route_pin_four, 2), $past(route_pin_three, 2)})
    else $error("TX source not from route pins");
  AST_UNLOCK: assert property (
    hw_mode |-> serial_wire_count_pin_oe
    && serial_wire_count_pin_out == rx_unlock)
    else $error("Unlock pin wrong");
  AST_SUBFRAME: assert property (
    rx_subframe_strobe ##1 hw_mode
    |-> subframe_indicator == $past(rx_subframe_a))
    else $error("Sub-frame indicator wrong");
  AST_BLOCK: assert property (
    rx_subframe_strobe && rx_subframe_a && rx_block_start ##1 hw_mode
    |-> block_start_flag)
    else $error("Block flag not raised");
  AST_FORMAT: assert property (
    rst_age == 2'h3 && hw_mode && $past(chip_select_pin, 2)
    && $past(serial_clock_pin, 2) |-> port_format == FMT_I2S)
    else $error("Format strap ignored");
  AST_HW_MUTE: assert property (
    hw_mode && sy_reg[SY_MUTE] && !sy_reg[SY_FLT] |-> dac_soft_mute == 3'h7)
    else $error("Hardware mute not applied");
  AST_SW_MUTE: assert property (
    !hw_mode && mute_reg[MUT_PDIS] |-> dac_soft_mute == 3'h0)
    else $error("Mute pin not disabled");
  AST_ZERO_FLAG: assert property (
    sy_reg[SY_FLT] |-> mute_pin_oe && mute_pin_out == all_zero)
    else $error("Zero flag output wrong");
  AST_RATIO: assert property (
    hw_mode |-> primary_tx_clock_ratio == RATIO_256FS
    && bitclock_ratio_select == BCLK_64)
    else $error("Hardware clock ratios wrong");
  AST_CONCEAL: assert property (
    rx_subframe_strobe && bad |=> dac_path_sample == $past(good_reg[ch]))
    else $error("Bad sample not concealed");
  AST_TX_PASS: assert property (
    rx_subframe_strobe && !rx_validity |=> tx_path_sample == $past(rx_sample))
    else $error("TX path altered on non-validity error");
  AST_PWDN: assert property (
    rst_age == 2'h0 && !hw_mode |-> chip_powerdown)
    else $error("Software mode not powered down");
  AST_MCLK_IN: assert property (
    master_clock_pin_oe == 1'b0)
    else $error("Master clock pin driven");

  COV_HW: cover property (hw_mode && rx_subframe_strobe && bad);
  COV_SW_MUTE: cover property (!hw_mode && dac_soft_mute != 3'h0);
  COV_SPLIT: cover property (rx_used && port_clock_sel == CLK_EXT);
  COV_BLOCK: cover property (block_start_flag ##1 !block_start_flag);

endmodule

// ### test/hpcm_spdif_src.sv
`timescale 1ns/1ns
module hpcm_spdif_src #(
  parameter int OSC_HZ = 12000000
) (
  input wire logic hclk,
  output logic rx_subframe_strobe,
  output logic rx_subframe_a,
  output logic rx_channel_bit,
  output logic rx_block_start,
  output logic [23:0] rx_sample,
  output logic rx_parity_err,
  output logic rx_biphase_err,
  output logic rx_validity
);
  initial begin
    rx_subframe_strobe = 1'b0;
    {rx_subframe_a, rx_channel_bit, rx_block_start} = 3'h0;
    {rx_sample, rx_parity_err, rx_biphase_err, rx_validity} = 27'h0;
  end

  // Header is {sub-frame A, channel bit, block start}, err is {par, bip, val}
  task automatic send(input logic [2:0] hdr, input logic [23:0] s,
                      input logic [2:0] err);
    // Paced by the system clock, so the stream stays synchronous
    @(posedge hclk);
    #1;
    rx_subframe_strobe <= 1'b1;
    {rx_subframe_a, rx_channel_bit, rx_block_start} <= hdr;
    {rx_sample, rx_parity_err, rx_biphase_err, rx_validity} <= {s, err};
    @(posedge hclk);
    #1;
    // Inverted after the strobe so stale fields never pass as fresh ones
    rx_subframe_strobe <= 1'b0;
    {rx_subframe_a, rx_channel_bit, rx_block_start} <= ~hdr;
    {rx_sample, rx_parity_err, rx_biphase_err, rx_validity} <= ~{s, err};
  endtask
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import hpcm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, rdy_s;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd_s;
  wire logic hready;
  logic control_method_select_pin, route_pin_one, route_pin_two;
  logic route_pin_three, route_pin_four, chip_select_pin, serial_clock_pin;
  logic mute_pin_in, mute_pin_float, serial_in_pin, global_powerdown_pin;
  logic rx_unlock, rx_pcm_n, rx_audio_n;
  logic [2:0] dac_zero;
  logic rx_subframe_strobe, rx_subframe_a, rx_channel_bit, rx_block_start;
  logic [23:0] rx_sample, dac_path_sample, tx_path_sample;
  logic rx_parity_err, rx_biphase_err, rx_validity;
  logic hw_mode, converter_source_select, primary_tx_source_select;
  logic [1:0] spdif_out_source_select, port_format, bitclock_ratio_select;
  logic primary_tx_role_bit, chip_powerdown;
  logic [2:0] primary_tx_clock_ratio, dac_soft_mute;
  logic serial_wire_count_pin_out, serial_wire_count_pin_oe;
  logic serial_out_pin_out, serial_out_pin_oe, multifunction_pin_eight;
  logic subframe_indicator, block_start_flag, status_pins_oe;
  logic mute_pin_out, mute_pin_oe, dac_clock_sel, adc_clock_sel;
  logic port_clock_sel, port_clocks_oe, master_clock_pin_oe, sample_strobe;
  int error_cnt = 0;
  int total_checks = 0;

  assign hready = hreadyout;
  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    rdy_s <= hreadyout;
    rd_s <= hrdata;
  end

  hpcm_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .control_method_select_pin, .route_pin_one, .route_pin_two,
    .route_pin_three, .route_pin_four, .chip_select_pin, .serial_clock_pin,
    .mute_pin_in, .mute_pin_float, .serial_in_pin, .global_powerdown_pin,
    .rx_unlock, .rx_pcm_n, .rx_audio_n, .rx_subframe_strobe, .rx_subframe_a,
    .rx_channel_bit, .rx_block_start, .rx_sample, .rx_parity_err,
    .rx_biphase_err, .rx_validity, .dac_zero, .hw_mode,
    .converter_source_select, .primary_tx_source_select,
    .spdif_out_source_select, .port_format, .primary_tx_role_bit,
    .primary_tx_clock_ratio, .bitclock_ratio_select, .dac_soft_mute,
    .chip_powerdown, .serial_wire_count_pin_out, .serial_wire_count_pin_oe,
    .serial_out_pin_out, .serial_out_pin_oe, .multifunction_pin_eight,
    .subframe_indicator, .block_start_flag, .status_pins_oe, .mute_pin_out,
    .mute_pin_oe, .dac_clock_sel, .adc_clock_sel, .port_clock_sel,
    .port_clocks_oe, .master_clock_pin_oe, .dac_path_sample,
    .tx_path_sample, .sample_strobe);

  hpcm_spdif_src src (.hclk, .rx_subframe_strobe, .rx_subframe_a,
    .rx_channel_bit, .rx_block_start, .rx_sample, .rx_parity_err,
    .rx_biphase_err, .rx_validity);

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge hclk);
      #1;
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (rdy_s !== 1'b1 && n < 20);
    if (rdy_s !== 1'b1) begin
      error_cnt++;
      close_out();
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = rd_s;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask

  task automatic rdchk(input string nm, input logic [5:0] idx,
                       input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    chk(nm, x, exp);
  endtask

  task automatic t_regs();
    chk("hw_mode", hw_mode, 1'b0);
    chk("pwdn", chip_powerdown, 1'b1);
    chk("stat_oe", {status_pins_oe, serial_out_pin_oe}, 2'b00);
    chk("hresp", hresp, 1'b0);
    rdchk("id1", IDX_ID1, 32'h5a);
    rdchk("id2", IDX_ID2, 32'h3c);
    rdchk("rev", IDX_REV, 32'h01);
    rdchk("cfg", IDX_CFG, {18'h0, CFG_RST});
    rdchk("mute", IDX_MUTE, {28'h0, MUT_RST});
    rdchk("stat", IDX_STAT, 32'h10);
    wr(6'h3f, 32'hffff);
    rdchk("unmapped", 6'h3f, 32'h0);
    wr(IDX_CFG, 32'h1 | (32'h1 << CFG_CONT_RD));
    chk("sw_converter_source_select", converter_source_select, 1'b1);
    rdchk("id1_cont", IDX_ID1, 32'h0);
    wr(IDX_CFG, {18'h0, CFG_RST});
  endtask

  task automatic t_swmute();
    mute_pin_in <= 1'b1;
    wr(IDX_MUTE, 32'h5);
    tick(2);
    chk("sw_mute", dac_soft_mute, 3'h5);
    wr(IDX_MUTE, 32'hd);
    chk("sw_mute_dis", dac_soft_mute, 3'h0);
    mute_pin_in <= 1'b0;
    wr(IDX_MUTE, 32'h0);
  endtask

  task automatic t_hwroute();
    logic [1:0] kb;
    control_method_select_pin <= 1'b1;
    tick(3);
    chk("hw_mode", hw_mode, 1'b1);
    chk("ratio", {primary_tx_clock_ratio, bitclock_ratio_select},
        {RATIO_256FS, BCLK_64});
    for (int k = 0; k < 4; k++) begin
      kb = 2'(k);
      {route_pin_two, route_pin_one} <= kb;
      {route_pin_four, route_pin_three} <= kb;
      {chip_select_pin, serial_clock_pin} <= kb;
      serial_in_pin <= kb[0];
      global_powerdown_pin <= kb[1];
      tick(3);
      chk("dac_ptx_src", {primary_tx_source_select, converter_source_select},
          kb);
      chk("tx_src", spdif_out_source_select, kb);
      chk("fmt", port_format, kb);
      chk("role", primary_tx_role_bit, kb[0]);
      chk("pwdn", chip_powerdown, kb[1]);
    end
  endtask

  task automatic t_clock();
    {route_pin_one, route_pin_two, route_pin_three, route_pin_four} <= 4'h0;
    serial_in_pin <= 1'b1;
    global_powerdown_pin <= 1'b0;
    tick(3);
    chk("clk_int", {dac_clock_sel, adc_clock_sel, port_clock_sel},
        {3{CLK_INT}});
    chk("clk_pins", {port_clocks_oe, master_clock_pin_oe}, 2'b10);
    route_pin_two <= 1'b1;
    tick(3);
    chk("clk_split", {dac_clock_sel, port_clock_sel},
        {CLK_INT, CLK_EXT});
    // Receiver unused: board must feed the converter clock pin
    route_pin_one <= 1'b1;
    route_pin_three <= 1'b1;
    tick(3);
    chk("clk_ext", {dac_clock_sel, adc_clock_sel, port_clock_sel},
        {3{CLK_EXT}});
  endtask

  task automatic t_status();
    chk("stat_oe_hw", {status_pins_oe, serial_out_pin_oe, mute_pin_oe},
        3'b110);
    rx_unlock <= 1'b1;
    tick(1);
    chk("unlock", {serial_wire_count_pin_oe, serial_wire_count_pin_out},
        2'b11);
    rx_unlock <= 1'b0;
    tick(1);
    chk("lock", serial_wire_count_pin_out, 1'b0);
    for (int j = 0; j < 4; j++) begin
      {rx_pcm_n, rx_audio_n} <= 2'(j);
      tick(1);
      chk("non_audio", serial_out_pin_out, j != 0);
    end
    mute_pin_in <= 1'b1;
    tick(3);
    chk("hw_mute", dac_soft_mute, 3'h7);
    mute_pin_float <= 1'b1;
    dac_zero <= 3'h7;
    tick(3);
    chk("float", {mute_pin_oe, mute_pin_out, dac_soft_mute}, 5'b11000);
    dac_zero <= 3'h3;
    tick(1);
    chk("zero", mute_pin_out, 1'b0);
    mute_pin_in <= 1'b0;
    mute_pin_float <= 1'b0;
    tick(3);
    chk("unmute", dac_soft_mute, 3'h0);
  endtask

  task automatic t_spdif();
    src.send(3'b111, 24'h111111, 3'h0);
    chk("pins_a", {block_start_flag, subframe_indicator,
        multifunction_pin_eight, sample_strobe}, 4'hf);
    src.send(3'b000, 24'h222222, 3'h0);
    chk("pins_b", {block_start_flag, subframe_indicator,
        multifunction_pin_eight}, 3'b100);
    src.send(3'b100, 24'h333333, 3'h4);
    chk("blk_end", block_start_flag, 1'b0);
    chk("par", {dac_path_sample, tx_path_sample},
        {24'h111111, 24'h333333});
    src.send(3'b100, 24'h555555, 3'h0);
    src.send(3'b100, 24'h666666, 3'h1);
    chk("val", {dac_path_sample, tx_path_sample}, {2{24'h555555}});
    src.send(3'b000, 24'h777777, 3'h2);
    chk("bip", {dac_path_sample, tx_path_sample},
        {24'h222222, 24'h777777});
  endtask

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {control_method_select_pin, route_pin_one, route_pin_two} = 3'h0;
    {route_pin_three, route_pin_four, chip_select_pin} = 3'h0;
    {serial_clock_pin, mute_pin_in, mute_pin_float, serial_in_pin} = 4'h0;
    {global_powerdown_pin, rx_unlock, rx_pcm_n, rx_audio_n} = 4'h0;
    dac_zero = 3'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    tick(1);
    t_regs();
    t_swmute();
    t_hwroute();
    t_clock();
    t_status();
    t_spdif();
    close_out();
  end
endmodule
